//--- rtl/bsx_pkg.sv
/*
 * bsx_pkg: opcode fields, address constants and quarter-phase states for the
 * bit-skip / fill / rotate execution block.
 * assumes: 8-bit data core, 16-bit instruction words, 4 quarter-phases per cycle.
 */
package bsx_pkg;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [3:0] SKIP_IF_BIT_SET_NIB = 4'hA;
    localparam logic [3:0] SKIP_IF_BIT_CLEAR_NIB = 4'hB;
    localparam logic [7:0] FILL_ONES_TOP = 8'h68;
    localparam logic [5:0] ROTATE_RIGHT_NOCARRY_TOP = 6'h10;
    localparam int OPC_NIB_POS = 12;
    localparam int BIT_IDX_POS = 9;
    localparam int ACC_SEL_POS = 8;
    localparam int DEST_POS = 9;

    // ------------------------------------------------------------------
    // data and addressing constants
    // ------------------------------------------------------------------
    localparam logic [7:0] FILL_VALUE = 8'hFF;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [1:0] SKIP_IDLE_ONE = 2'h1;
    localparam logic [1:0] SKIP_IDLE_TWO = 2'h2;

    typedef enum logic [1:0] {
        BSX_Q1,
        BSX_Q2,
        BSX_Q3,
        BSX_Q4
    } bsx_phase_type;

    typedef enum logic [2:0] {
        BSX_OP_OTHER,
        BSX_OP_SKIP_SET,
        BSX_OP_SKIP_CLR,
        BSX_OP_FILL,
        BSX_OP_ROR
    } bsx_op_type;

endpackage : bsx_pkg

//--- rtl/bsx_addr_gen.sv
/*
 * bsx_addr_gen: turns the access selector and 8-bit file field into a 12-bit
 * data-memory address.
 * assumes: index base comes from the core's indirect pointer register.
 */
`timescale 1ns/1ps
module bsx_addr_gen (
    // operand
    input wire logic acc_sel_i,
    input wire logic [7:0] file_i,
    // mode and bank
    input wire logic ext_set_en_i,
    input wire logic [3:0] bank_selection_reg_i,
    input wire logic [11:0] index_base_i,
    // result
    output logic [11:0] addr_o,
    output logic indexed_o
);
    always_comb begin
        indexed_o = 1'b0;
        if (acc_sel_i) begin
            addr_o = {bank_selection_reg_i, file_i};
        end else if (ext_set_en_i && file_i <= bsx_pkg::INDEXED_LIMIT) begin
            addr_o = index_base_i + {4'h0, file_i};
            indexed_o = 1'b1;
        end else if (file_i < bsx_pkg::ACCESS_SPLIT) begin
            addr_o = {bsx_pkg::BANK_RESET, file_i};
        end else begin
            addr_o = {bsx_pkg::ACCESS_HIGH_BANK, file_i};
        end
    end
endmodule : bsx_addr_gen

//--- rtl/bsx_exec.sv
/*
 * bsx_exec: executes bit-test skips, fill-with-ones and rotate-right without
 * carry across the four quarter-phases of an instruction cycle.
 * assumes: the fetch unit presents instr_i and next_two_word_i stable from Q1
 * to Q4; file reads return rd_data_i combinationally.
 */
`timescale 1ns/1ps
// Behaviour
// - taken skip adds one idle cycle, two if next is 2-word
// - fill writes FFh to the file register, flags untouched
// - access bit 0 selects the fixed access bank
// - access bit 1 joins bank select register with file field
// - access 0 with extended set and file <= 5Fh uses indexed offset
module bsx_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // instruction
    input wire logic [15:0] instr_i,
    input wire logic next_two_word_i,
    // core state
    input wire logic ext_set_en_i,
    input wire logic [3:0] bank_selection_reg_i,
    input wire logic [11:0] index_base_i,
    // data memory
    output logic [11:0] addr_o,
    input wire logic [7:0] rd_data_i,
    output logic rd_en_o,
    output logic wr_en_o,
    output logic [7:0] wr_data_o,
    // working register and flags
    output logic w_wr_en_o,
    output logic [7:0] w_data_o,
    output logic flag_wr_en_o,
    output logic flag_neg_o,
    output logic flag_zero_o,
    // sequencing
    output logic instr_done_o,
    output logic idle_cycle_op_o,
    output logic [1:0] phase_o
);
    function automatic bsx_pkg::bsx_op_type decode_op(input logic [15:0] ins);
        bsx_pkg::bsx_op_type op;
        op = bsx_pkg::BSX_OP_OTHER;
        if (ins[15:12] == bsx_pkg::SKIP_IF_BIT_SET_NIB) op = bsx_pkg::BSX_OP_SKIP_SET;
        else if (ins[15:12] == bsx_pkg::SKIP_IF_BIT_CLEAR_NIB) op = bsx_pkg::BSX_OP_SKIP_CLR;
        // low bit of the top byte is the access selector, so it is masked off
        else if ({ins[15:9], 1'b0} == bsx_pkg::FILL_ONES_TOP) op = bsx_pkg::BSX_OP_FILL;
        else if (ins[15:10] == bsx_pkg::ROTATE_RIGHT_NOCARRY_TOP) op = bsx_pkg::BSX_OP_ROR;
        return op;
    endfunction : decode_op

    // ------------------------------------------------------------------
    // decode and address
    // ------------------------------------------------------------------
    bsx_pkg::bsx_op_type op;
    logic [2:0] bit_idx;
    logic acc_sel;
    logic [11:0] addr;
    logic skip_op;
    logic bit_val;
    logic take_skip;
    logic [7:0] ror_val;

    always_comb begin
        op = decode_op(instr_i);
        bit_idx = instr_i[bsx_pkg::BIT_IDX_POS +: 3];
        acc_sel = instr_i[bsx_pkg::ACC_SEL_POS];
        skip_op = (op == bsx_pkg::BSX_OP_SKIP_SET) || (op == bsx_pkg::BSX_OP_SKIP_CLR);
        bit_val = rd_data_i[bit_idx];
        take_skip = skip_op && ((op == bsx_pkg::BSX_OP_SKIP_SET) == bit_val);
        ror_val = {rd_data_i[0], rd_data_i[7:1]};
    end

    bsx_addr_gen u_addr (
        .acc_sel_i(acc_sel),
        .file_i(instr_i[7:0]),
        .ext_set_en_i(ext_set_en_i),
        .bank_selection_reg_i(bank_selection_reg_i),
        .index_base_i(index_base_i),
        .addr_o(addr),
        .indexed_o()
    );

    // ------------------------------------------------------------------
    // quarter-phase sequencer
    // ------------------------------------------------------------------
    bsx_pkg::bsx_phase_type phase;
    bsx_pkg::bsx_phase_type next_phase;
    logic [1:0] idle_left;
    logic [1:0] next_idle_left;
    logic [7:0] latch;
    logic [7:0] next_latch;
    logic skip_hit;
    logic next_skip_hit;

    always_comb begin
        next_latch = latch;
        next_skip_hit = skip_hit;
        next_idle_left = idle_left;
        case (phase)
            bsx_pkg::BSX_Q1: next_phase = bsx_pkg::BSX_Q2;
            bsx_pkg::BSX_Q2: next_phase = bsx_pkg::BSX_Q3;
            bsx_pkg::BSX_Q3: next_phase = bsx_pkg::BSX_Q4;
            bsx_pkg::BSX_Q4: next_phase = bsx_pkg::BSX_Q1;
            default: next_phase = bsx_pkg::BSX_Q1;
        endcase
        if (idle_left == 2'h0) begin
            if (phase == bsx_pkg::BSX_Q2) begin
                next_latch = (op == bsx_pkg::BSX_OP_FILL) ? bsx_pkg::FILL_VALUE : ror_val;
                next_skip_hit = take_skip;
            end
            if (phase == bsx_pkg::BSX_Q4 && skip_hit) begin
                // the following slot is flushed, cost grows with its length
                next_idle_left = next_two_word_i ? bsx_pkg::SKIP_IDLE_TWO : bsx_pkg::SKIP_IDLE_ONE;
                next_skip_hit = 1'b0;
            end
        end else if (phase == bsx_pkg::BSX_Q4) begin
            next_idle_left = idle_left - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            phase <= bsx_pkg::BSX_Q1;
            idle_left <= 2'h0;
            latch <= 8'h00;
            skip_hit <= 1'b0;
        end else begin
            phase <= next_phase;
            idle_left <= next_idle_left;
            latch <= next_latch;
            skip_hit <= next_skip_hit;
        end
    end

    // ------------------------------------------------------------------
    // write-back
    // ------------------------------------------------------------------
    logic active;
    logic wb_phase;
    logic to_file;
    logic next_wr_en;
    logic next_w_wr_en;
    logic next_flag_wr_en;
    logic wr_en;
    logic w_wr_en;
    logic flag_wr_en;
    logic [7:0] wb_data;
    logic [11:0] addr_q;
    logic flag_neg;
    logic flag_zero;
    logic done;

    always_comb begin
        active = (idle_left == 2'h0);
        wb_phase = active && (phase == bsx_pkg::BSX_Q3);
        to_file = instr_i[bsx_pkg::DEST_POS];
        next_wr_en = wb_phase && ((op == bsx_pkg::BSX_OP_FILL)
            || (op == bsx_pkg::BSX_OP_ROR && to_file));
        next_w_wr_en = wb_phase && op == bsx_pkg::BSX_OP_ROR && !to_file;
        next_flag_wr_en = wb_phase && op == bsx_pkg::BSX_OP_ROR;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_en <= 1'b0;
            w_wr_en <= 1'b0;
            flag_wr_en <= 1'b0;
            wb_data <= 8'h00;
            addr_q <= 12'h000;
            flag_neg <= 1'b0;
            flag_zero <= 1'b0;
            done <= 1'b0;
        end else begin
            wr_en <= next_wr_en;
            w_wr_en <= next_w_wr_en;
            flag_wr_en <= next_flag_wr_en;
            wb_data <= latch;
            addr_q <= addr;
            flag_neg <= next_flag_wr_en ? latch[7] : flag_neg;
            flag_zero <= next_flag_wr_en ? (latch == 8'h00) : flag_zero;
            done <= (phase == bsx_pkg::BSX_Q3);
        end
    end

    assign addr_o = addr_q;
    assign rd_en_o = active && phase == bsx_pkg::BSX_Q2;
    assign wr_en_o = wr_en;
    assign wr_data_o = wb_data;
    assign w_wr_en_o = w_wr_en;
    assign w_data_o = wb_data;
    assign flag_wr_en_o = flag_wr_en;
    assign flag_neg_o = flag_neg;
    assign flag_zero_o = flag_zero;
    assign instr_done_o = done;
    assign idle_cycle_op_o = !active;
    assign phase_o = phase;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_fill_value;
        @(posedge clk_i) disable iff (!nrst_i)
        (wb_phase && op == bsx_pkg::BSX_OP_FILL) |=> (wr_en && wr_data_o == 8'hFF && !flag_wr_en);
    endproperty
    a_fill_value: assert property (p_fill_value) else $error("fill did not write FFh");

    property p_skip_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (phase == bsx_pkg::BSX_Q4 && active && skip_hit && !next_two_word_i) |=> idle_cycle_op_o [*4] ##1 !idle_cycle_op_o;
    endproperty
    a_skip_idle: assert property (p_skip_idle) else $error("skip idle not one cycle");

    property p_ror_flags;
        @(posedge clk_i) disable iff (!nrst_i)
        next_flag_wr_en |=> (flag_zero_o == (wb_data == 8'h00)) && (flag_neg_o == wb_data[7]);
    endproperty
    a_ror_flags: assert property (p_ror_flags) else $error("rotate flags wrong");

    property p_no_skip_idle;
        @(posedge clk_i) disable iff (!nrst_i)
        (active && phase == bsx_pkg::BSX_Q4 && !skip_hit) |=> !idle_cycle_op_o;
    endproperty
    a_no_skip_idle: assert property (p_no_skip_idle) else $error("idle without skip");

    property p_skip_idle_two;
        @(posedge clk_i) disable iff (!nrst_i)
        (phase == bsx_pkg::BSX_Q4 && active && skip_hit && next_two_word_i)
            |=> idle_cycle_op_o [*8] ##1 !idle_cycle_op_o;
    endproperty
    a_skip_idle_two: assert property (p_skip_idle_two) else $error("skip idle not two cycles");

    property p_idle_quiet;
        @(posedge clk_i) disable iff (!nrst_i)
        idle_cycle_op_o |-> (!rd_en_o && !wr_en_o && !w_wr_en_o && !flag_wr_en_o);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("access during idle cycle");

    property p_bank_addr;
        @(posedge clk_i) disable iff (!nrst_i)
        (phase == bsx_pkg::BSX_Q1 && acc_sel) |=> (addr_o == {$past(bank_selection_reg_i), $past(instr_i[7:0])});
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
endmodule : bsx_exec

//--- test/tb.sv
/*
 * tb: table-driven bench for bsx_exec covering fill, rotate and bit-skip.
 * assumes: one clk_i edge per quarter-phase; inputs driven on falling edges.
 */
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0] rd;
        logic ext;
        logic [3:0] bank_selection_reg;
        logic [11:0] adr;
        logic [4:0] ctl;
        logic [7:0] dat;
        logic [1:0] idl;
    } bsx_row_type;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic next_two_word_i = 1'b0;
    logic ext_set_en_i = 1'b0;
    logic [3:0] bank_selection_reg_i = 4'h0;
    logic [11:0] index_base_i = 12'h300;
    logic [7:0] rd_data_i = 8'h00;
    logic [11:0] addr_o;
    logic rd_en_o, wr_en_o, w_wr_en_o, flag_wr_en_o, flag_neg_o, flag_zero_o;
    logic [7:0] wr_data_o, w_data_o;
    logic instr_done_o, idle_cycle_op_o;
    logic [1:0] phase_o;
    logic en = 1'b0;
    logic ez = 1'b0;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    // ctl = {file write, w write, flag write, n, z}
    bsx_row_type rows [14] = '{
        '{16'h6820, 8'h00, 1'b0, 4'h0, 12'h020, 5'h10, 8'hFF, 2'h0},
        '{16'h6934, 8'h00, 1'b0, 4'h5, 12'h534, 5'h10, 8'hFF, 2'h0},
        '{16'h6860, 8'h00, 1'b0, 4'h0, 12'hF60, 5'h10, 8'hFF, 2'h0},
        '{16'h685F, 8'h00, 1'b1, 4'h0, 12'h35F, 5'h10, 8'hFF, 2'h0},
        '{16'h6860, 8'h00, 1'b1, 4'h0, 12'hF60, 5'h10, 8'hFF, 2'h0},
        '{16'h4210, 8'hD7, 1'b0, 4'h0, 12'h010, 5'h16, 8'hEB, 2'h0},
        '{16'h4122, 8'h01, 1'b0, 4'h2, 12'h222, 5'h0E, 8'h80, 2'h0},
        '{16'h4005, 8'h00, 1'b0, 4'h0, 12'h005, 5'h0D, 8'h00, 2'h0},
        '{16'h4207, 8'h02, 1'b0, 4'h0, 12'h007, 5'h14, 8'h01, 2'h0},
        '{16'hA240, 8'hFD, 1'b0, 4'h0, 12'h040, 5'h00, 8'h00, 2'h0},
        '{16'hA240, 8'h02, 1'b0, 4'h0, 12'h040, 5'h00, 8'h00, 2'h1},
        '{16'hBF12, 8'h7F, 1'b0, 4'h3, 12'h312, 5'h00, 8'h00, 2'h2},
        '{16'hB008, 8'h01, 1'b0, 4'h0, 12'h008, 5'h00, 8'h00, 2'h0},
        '{16'hB010, 8'h00, 1'b1, 4'h0, 12'h310, 5'h00, 8'h00, 2'h1}
    };

    bsx_exec u_bsx_exec (
        .clk_i(clk_i), .nrst_i(nrst_i), .instr_i(instr_i), .next_two_word_i(next_two_word_i),
        .ext_set_en_i(ext_set_en_i), .bank_selection_reg_i(bank_selection_reg_i),
        .index_base_i(index_base_i), .addr_o(addr_o), .rd_data_i(rd_data_i), .rd_en_o(rd_en_o),
        .wr_en_o(wr_en_o), .wr_data_o(wr_data_o), .w_wr_en_o(w_wr_en_o), .w_data_o(w_data_o),
        .flag_wr_en_o(flag_wr_en_o), .flag_neg_o(flag_neg_o), .flag_zero_o(flag_zero_o),
        .instr_done_o(instr_done_o), .idle_cycle_op_o(idle_cycle_op_o), .phase_o(phase_o)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    task cmp_bit(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : cmp_bit

    task cmp_vec(input string nm, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : cmp_vec

    // bounded wait for a phase, checked on falling edges
    task to_phase(input logic [1:0] p);
        int k;
        k = 0;
        while (phase_o !== p && k < 16) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 16) cmp_vec("phase", {10'h000, p}, {10'h000, phase_o});
    endtask : to_phase

    task run_row(input bsx_row_type r);
        to_phase(2'h0);
        instr_i = r.ins;
        rd_data_i = r.rd;
        ext_set_en_i = r.ext;
        bank_selection_reg_i = r.bank_selection_reg;
        next_two_word_i = (r.idl == 2'h2);
        to_phase(2'h1);
        cmp_bit("rd_en", 1'b1, rd_en_o);
        cmp_bit("idle", 1'b0, idle_cycle_op_o);
        cmp_vec("addr", r.adr, addr_o);
        to_phase(2'h3);
        cmp_bit("wr_en", r.ctl[4], wr_en_o);
        cmp_bit("w_wr_en", r.ctl[3], w_wr_en_o);
        cmp_bit("flag_wr_en", r.ctl[2], flag_wr_en_o);
        cmp_bit("done", 1'b1, instr_done_o);
        if (r.ctl[4]) cmp_vec("wr_data", {4'h0, r.dat}, {4'h0, wr_data_o});
        if (r.ctl[3]) cmp_vec("w_data", {4'h0, r.dat}, {4'h0, w_data_o});
        if (r.ctl[2]) begin
            en = r.ctl[1];
            ez = r.ctl[0];
        end
        cmp_bit("neg", en, flag_neg_o);
        cmp_bit("zero", ez, flag_zero_o);
        repeat (4 * r.idl) begin
            @(negedge clk_i);
            cmp_bit("idle", 1'b1, idle_cycle_op_o);
            cmp_bit("rd_en", 1'b0, rd_en_o);
            cmp_bit("wr_en", 1'b0, wr_en_o);
        end
        $display("row %h done", r.ins);
    endtask : run_row

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        // unknown opcode writes nothing
        to_phase(2'h0);
        instr_i = 16'hFFFF;
        to_phase(2'h3);
        cmp_bit("wr_en", 1'b0, wr_en_o);
        cmp_bit("w_wr_en", 1'b0, w_wr_en_o);
        cmp_bit("flag_wr_en", 1'b0, flag_wr_en_o);
        $display("unknown opcode test done");
        // reset in Q1 of the first idle cycle after a taken skip
        to_phase(2'h0);
        instr_i = 16'hA240;
        rd_data_i = 8'h02;
        next_two_word_i = 1'b1;
        to_phase(2'h3);
        @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        cmp_vec("phase", 12'h000, {10'h000, phase_o});
        cmp_bit("idle", 1'b0, idle_cycle_op_o);
        cmp_bit("neg", 1'b0, flag_neg_o);
        en = 1'b0;
        ez = 1'b0;
        nrst_i = 1'b1;
        run_row(rows[0]);
        $display("reset test done");
        report_and_stop();
    end
endmodule : tb
